// ---- pkg/asb_params.svh ----
`ifndef ASB_PARAMS_SVH
`define ASB_PARAMS_SVH

// Data-memory location of the status register, both banks
`define ASB_STATUS_ADDR_B0   8'h03
`define ASB_STATUS_ADDR_B1   8'h83
// Register index on the bus; byte address is four times the index
`define ASB_STATUS_INDEX     8'h03
`define ASB_STATUS_BYTE_ADDR 8'h0C

// Field positions inside the status byte
`define ASB_BIT_IND_BANK     7
`define ASB_BIT_UPPER_BANK   6
`define ASB_BIT_BANK_SEL     5
`define ASB_BIT_TIMEOUT      4
`define ASB_BIT_POWERDOWN    3
`define ASB_BIT_ZERO         2
`define ASB_BIT_DIGIT_CARRY  1
`define ASB_BIT_CARRY        0

// Status value after reset: both reset-cause flags set, the rest clear
`define ASB_STATUS_RESET     8'h18

`endif

// ---- pkg/asb_pkg.sv ----
package asb_pkg;

  // Operation kinds presented by the core on the instruction port
  typedef enum logic [2:0]
  {
    ASB_OP_MOVE,   // Plain data move, touches no flag
    ASB_OP_CLEAR,  // Clear file, sets zero flag only
    ASB_OP_AND,    // Logic op, zero flag only
    ASB_OP_ADD,    // Arithmetic, all three flags
    ASB_OP_SUB     // Arithmetic, carries act as inverted borrow
  } asb_op_t;

  // Whole state of the status block
  typedef struct packed
  {
    logic [7:0] status;     // The one physical status register
    logic [7:0] op_result;  // Last operation result
    logic [7:0] op_rdata;   // Last file value read by an operation
  } asb_state_t;

endpackage

// ---- rtl/asb_flag_alu.sv ----
`timescale 1ns/1ps
`include "asb_params.svh"

// ============================================================
// Flag logic for one operation, purely combinational
// ============================================================
module asb_flag_alu
#(
  parameter int WIDTH = 8
)
(
  // Operation and operands
  input  wire asb_pkg::asb_op_t op,
  input  wire logic [WIDTH-1:0] file_val,
  input  wire logic [WIDTH-1:0] w_val,
  // Result and flags
  output logic [WIDTH-1:0]      result,
  output logic                  zero,
  output logic                  digit_carry,
  output logic                  carry
);

  logic [WIDTH:0] sum;       // Sum with carry out
  logic [4:0]     nib_sum;   // Low nibble sum with carry out
  logic [WIDTH-1:0] addend;  // W or its ones complement

  // ============================================================
  // Add, or subtract by adding the twos complement of W
  // ============================================================
  always_comb
  begin
    addend  = (op == asb_pkg::ASB_OP_SUB) ? ~w_val : w_val;
    // Carry in of one completes the twos complement; no borrow gives one
    sum     = {1'b0, file_val} + {1'b0, addend}
              + {{WIDTH{1'b0}}, (op == asb_pkg::ASB_OP_SUB)};           // RULE8
    nib_sum = {1'b0, file_val[3:0]} + {1'b0, addend[3:0]}
              + {4'h0, (op == asb_pkg::ASB_OP_SUB)};                    // RULE8
    unique case (op)
      asb_pkg::ASB_OP_MOVE:  result = w_val;
      asb_pkg::ASB_OP_CLEAR: result = '0;
      asb_pkg::ASB_OP_AND:   result = file_val & w_val;
      asb_pkg::ASB_OP_ADD,
      asb_pkg::ASB_OP_SUB:   result = sum[WIDTH-1:0];
      // Codes 5 to 7 are unused; give a known result rather than a latch
      default:               result = '0;
    endcase
    zero        = (result == '0);                                       // RULE10
    carry       = sum[WIDTH];                                           // RULE11
    digit_carry = nib_sum[4];
  end

endmodule

// ---- rtl/asb_status_core.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "asb_params.svh"

// Behaviour
// RULE1: Status reached at 03h and 83h alike
// RULE2: Status accepts any instruction as destination
// RULE3: Flag-affecting ops block data write to flags
// RULE4: Reset-cause flags ignore every instruction write
// RULE5: Clear of status gives pattern 000uuluu
// RULE6: Software alters status with flag-neutral instructions
// RULE7: Software keeps the two top bits zero
// RULE8: Subtraction carries mean no borrow
// RULE9: Powerdown set by power-up/watchdog clear, cleared sleep
// RULE10: Zero flag follows zero result
// RULE11: Carry flag follows carry out of MSB
// RULE12: Bit 5 selects direct bank, resets zero
// RULE13: Unimplemented locations read zero, ignore writes

module asb_status_core
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core instruction port, one operation per cycle
  input  wire logic              op_valid,
  input  wire asb_pkg::asb_op_t  op_code,
  input  wire logic [6:0]        op_dir_addr,
  input  wire logic              op_dest_file,
  input  wire logic [7:0]        op_w,
  // Reset-cause events, one-cycle pulses
  input  wire logic              watchdog_clear_instr,
  input  wire logic              sleep_instr,
  input  wire logic              watchdog_timeout,
  // Results and status
  output logic [7:0]             op_result,
  output logic [7:0]             op_rdata,
  output logic [7:0]             status_out,
  output logic                   direct_bank_select,
  output logic [7:0]             op_full_addr
);

  asb_pkg::asb_state_t s_reg;   // Registered state
  asb_pkg::asb_state_t s_next;  // Next state

  logic       apb_hit;     // Bus address decodes to the status word
  logic       apb_wr;      // Bus write taken this edge
  logic       op_hit;      // Operation targets the status register
  logic [7:0] file_val;    // File value seen by the operation
  logic [7:0] alu_res;     // Operation result
  logic       alu_z;       // Zero flag from flag logic
  logic       alu_dc;      // Digit carry from flag logic
  logic       alu_c;       // Carry from flag logic
  logic       aff_z;       // Operation updates zero flag
  logic       aff_cy;      // Operation updates both carries

  // ============================================================
  // Address decode
  // ============================================================
  // Direct address is widened by the bank select bit
  assign op_full_addr = {s_reg.status[`ASB_BIT_BANK_SEL], op_dir_addr};  // RULE12
  // Both bank images land on the one register
  assign op_hit = (op_full_addr == `ASB_STATUS_ADDR_B0)
                  || (op_full_addr == `ASB_STATUS_ADDR_B1);                // RULE1
  // Anything else reads zero to this block
  assign file_val = op_hit ? s_reg.status : 8'h00;                         // RULE13

  // ============================================================
  // APB slave: zero wait states, error on unmapped words
  // ============================================================
  assign apb_hit = (paddr == ADDR_W'(`ASB_STATUS_BYTE_ADDR));
  assign apb_wr  = psel && penable && pwrite && apb_hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  // Read mux picks straight from the register, no added latency
  assign prdata  = apb_hit ? {24'h000000, s_reg.status} : 32'h00000000;

  // ============================================================
  // Flag logic
  // ============================================================
  asb_flag_alu #(.WIDTH(8)) u_alu
  (
    .op          (op_code),
    .file_val    (file_val),
    .w_val       (op_w),
    .result      (alu_res),
    .zero        (alu_z),
    .digit_carry (alu_dc),
    .carry       (alu_c)
  );

  assign aff_cy = (op_code == asb_pkg::ASB_OP_ADD) || (op_code == asb_pkg::ASB_OP_SUB);
  assign aff_z  = aff_cy || (op_code == asb_pkg::ASB_OP_CLEAR)
                  || (op_code == asb_pkg::ASB_OP_AND);

  // ============================================================
  // Next-state logic
  // ============================================================
  always_comb
  begin
    s_next = s_reg;
    // Bus write behaves like a plain move into the register
    if (apb_wr)
    begin
      s_next.status[7:5] = pwdata[7:5];
      s_next.status[2:0] = pwdata[2:0];
      // Bits 4:3 are left alone: reset-cause flags are not writable
    end
    // Core operation is applied after the bus write, so it wins
    if (op_valid)
    begin
      s_next.op_result = alu_res;
      s_next.op_rdata  = file_val;
      // Result written back to the status register like any file
      if (op_dest_file && op_hit)                                          // RULE2
      begin
        s_next.status[7:5] = alu_res[7:5];                                 // RULE5
        // Flag-affecting ops lose the data write on all three flags
        if (!aff_z)
        begin
          s_next.status[2:0] = alu_res[2:0];                               // RULE3
        end
      end
      // Writes to any other location are dropped here
      // Flags then come from the flag logic
      if (aff_z)
      begin
        s_next.status[`ASB_BIT_ZERO] = alu_z;                              // RULE10
      end
      if (aff_cy)
      begin
        s_next.status[`ASB_BIT_DIGIT_CARRY] = alu_dc;                      // RULE8
        s_next.status[`ASB_BIT_CARRY]       = alu_c;                       // RULE11
      end
    end
    // Reset-cause flags move only on internal events
    if (watchdog_clear_instr)
    begin
      s_next.status[`ASB_BIT_TIMEOUT]   = 1'b1;                            // RULE4
      s_next.status[`ASB_BIT_POWERDOWN] = 1'b1;                            // RULE9
    end
    if (sleep_instr)
    begin
      s_next.status[`ASB_BIT_TIMEOUT]   = 1'b1;
      s_next.status[`ASB_BIT_POWERDOWN] = 1'b0;                            // RULE9
    end
    // A time-out is the rarer event and is never lost
    if (watchdog_timeout)
    begin
      s_next.status[`ASB_BIT_TIMEOUT] = 1'b0;                              // RULE4
    end
  end

  // ============================================================
  // State register; power-up sets both reset-cause flags
  // ============================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg.status    <= `ASB_STATUS_RESET;                                // RULE9 RULE12
      s_reg.op_result <= 8'h00;
      s_reg.op_rdata  <= 8'h00;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // Outputs
  // ============================================================
  assign op_result          = s_reg.op_result;
  assign op_rdata           = s_reg.op_rdata;
  assign status_out         = s_reg.status;
  assign direct_bank_select = s_reg.status[`ASB_BIT_BANK_SEL];

  // ============================================================
  // Checks
  // ============================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic quiet;  // No reset-cause event this cycle
  assign quiet = !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;

  logic [2:0] alu_flags;  // Flag triple from the flag logic, for history checks
  logic [8:0] add_sum;    // Plain add of the operands with carry out, kept apart from the ALU
  assign alu_flags = {alu_z, alu_dc, alu_c};
  assign add_sum   = {1'b0, file_val} + {1'b0, op_w};

  chk_mirror_read: assert property (                                       // RULE1
    op_valid && (op_dir_addr == 7'h03) |=> op_rdata == $past(s_reg.status))
    else $error("status image read mismatch");

  chk_flag_block: assert property (                                        // RULE3
    op_valid && op_dest_file && op_hit && aff_cy
    |=> status_out[2:0] == $past(alu_flags))
    else $error("flag bits took data write");

  chk_rcause_hold: assert property (                                       // RULE4
    quiet |=> $stable(status_out[4:3]))
    else $error("reset-cause flags changed without event");

  chk_clear_pattern: assert property (                                     // RULE5
    op_valid && op_dest_file && op_hit && op_code == asb_pkg::ASB_OP_CLEAR && !apb_wr
    |=> status_out[7:5] == 3'h0 && status_out[2] && $stable(status_out[1:0]))
    else $error("clear of status gave wrong pattern");

  chk_borrow_sense: assert property (                                      // RULE8
    op_valid && op_code == asb_pkg::ASB_OP_SUB && !(op_dest_file && op_hit) && !apb_wr
    |=> status_out[0] == ($past(file_val) >= $past(op_w)))
    else $error("subtract carry not inverse borrow");

  chk_sleep_pd: assert property (                                          // RULE9
    sleep_instr ##1 quiet [*2] |-> !status_out[3])
    else $error("powerdown flag not clear after sleep");

  chk_zero_flag: assert property (                                         // RULE10
    op_valid && aff_z |=> status_out[2] == (op_result == 8'h00))
    else $error("zero flag disagrees with result");

  chk_carry_add: assert property (                                         // RULE11
    op_valid && op_code == asb_pkg::ASB_OP_ADD && !apb_wr
    |=> status_out[0] == ($past(add_sum) > 9'h0FF))
    else $error("carry flag wrong after add");

  chk_bank_map: assert property (                                          // RULE12
    op_full_addr[7] == direct_bank_select)
    else $error("direct bank mapping wrong");

  chk_unimpl_zero: assert property (                                       // RULE13
    op_valid && !op_hit |=> op_rdata == 8'h00 && ($stable(status_out[7:5]) || $past(apb_wr)))
    else $error("unimplemented location not read as zero");

endmodule

// ---- sim/alu_status_and_bank_select_tb.sv ----
`timescale 1ns/1ps
`include "asb_params.svh"

// ============================================================
// Self-checking bench for the status register block
// ============================================================
module alu_status_and_bank_select_tb;
  logic               pclk, presetn;         // Clock and async reset
  logic               psel, penable, pwrite; // APB controls
  logic [7:0]         paddr;                 // APB byte address
  logic [31:0]        pwdata, prdata;        // APB data
  logic               pready, pslverr;       // APB answer
  logic               op_valid;              // Instruction strobe
  asb_pkg::asb_op_t   op_code;               // Operation kind
  logic [6:0]         op_dir_addr;           // Direct address
  logic               op_dest_file;          // Result to file
  logic [7:0]         op_w;                  // Working register
  logic               watchdog_clear_instr, sleep_instr, watchdog_timeout;
  logic [7:0]         op_result, op_rdata, status_out, op_full_addr;
  logic               direct_bank_select;
  int                 n_errors, tests_run;   // Verdict counters
  int                 m_st;                  // Model of the status byte
  logic [31:0]        rd;                    // Last APB read data
  logic               er;                    // Last APB error flag

  asb_status_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_dir_addr(op_dir_addr),
    .op_dest_file(op_dest_file), .op_w(op_w), .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout), .op_result(op_result),
    .op_rdata(op_rdata), .status_out(status_out), .direct_bank_select(direct_bank_select),
    .op_full_addr(op_full_addr));

  // ============================================================
  // Clock, 40 ns period
  // ============================================================
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compare one value and count it
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Verdict, the single end of the run
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Reset held for 8 cycles; model returns to the reset pattern
  task automatic rst_seq();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    m_st = 8'h18;
    @(negedge pclk);
    check("reset_status", status_out, 8'h18);
    check("reset_bank", direct_bank_select, 1'b0);
  endtask

  // APB transfer: setup, then access held until pready is seen high at a rising edge
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave stalls; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    // Answer taken at the completing edge, before the register moves on
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Reset-cause bits never take bus data
    if (wr && a == `ASB_STATUS_BYTE_ADDR)
      m_st = (m_st & 8'h18) | (d[7:0] & 8'hE7);
  endtask

  // One instruction, with the model worked out beside it
  task automatic op(input int k, input int d, input int df, input int w);
    int fa, f, r, s, dc;
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code <= asb_pkg::asb_op_t'(k[2:0]);
    op_dir_addr <= d[6:0];
    op_dest_file <= df[0];
    op_w <= w[7:0];
    fa = ((m_st >> 5) & 1) * 128 + d;
    f = (d == 3) ? m_st : 0;
    case (k)
      0: r = w;
      1: r = 0;
      2: r = f & w;
      3: r = f + w;
      default: r = f + 256 - w;
    endcase
    s = m_st;
    // Data reaches only the upper three bits; flags come from the operation
    // A move touches no flag, so it writes every bit but the reset-cause pair
    if (df != 0 && d == 3)
      s = (k == 0) ? ((s & 8'h18) | (r & 8'hE7)) : ((s & 8'h1F) | (r & 8'hE0));
    if (k != 0)
      s = (s & 8'hFB) | (((r & 255) == 0) ? 4 : 0);
    if (k >= 3)
    begin
      dc = (k == 3) ? (f & 15) + (w & 15) : (f & 15) + 16 - (w & 15);
      s = (s & 8'hFC) | ((dc > 15) ? 2 : 0) | ((r > 255) ? 1 : 0);
    end
    @(negedge pclk);
    check("full_addr", op_full_addr, fa);
    @(posedge pclk);
    op_valid <= 1'b0;
    m_st = s;
    @(negedge pclk);
    check("result", op_result, r & 255);
    check("rdata", op_rdata, f);
    check("status", status_out, s);
    check("bank", direct_bank_select, (s >> 5) & 1);
  endtask

  // Reset-cause event pulse: 0 watchdog clear, 1 sleep, 2 time-out
  task automatic ev(input int e);
    @(posedge pclk);
    watchdog_clear_instr <= (e == 0);
    sleep_instr <= (e == 1);
    watchdog_timeout <= (e == 2);
    m_st = (e == 2) ? (m_st & 8'hEF) : ((m_st | 8'h18) & ((e == 1) ? 8'hF7 : 8'hFF));
    @(posedge pclk);
    watchdog_clear_instr <= 1'b0;
    sleep_instr <= 1'b0;
    watchdog_timeout <= 1'b0;
    @(negedge pclk);
    check("event_status", status_out, m_st);
  endtask

  // ============================================================
  // Watchdog against a hang
  // ============================================================
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  // ============================================================
  // Main sequence
  // ============================================================
  initial
  begin
    {presetn, psel, penable, pwrite, op_valid, op_dest_file} = 6'h00;
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    op_code = asb_pkg::ASB_OP_MOVE;
    op_dir_addr = 7'h00;
    op_w = 8'h00;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(32'hF162));
    rst_seq();
    apb(1'b0, `ASB_STATUS_BYTE_ADDR, 32'h0, rd, er);
    check("apb_read", rd, 32'h18);
    // Unmapped place: write dropped, reads zero with an error
    apb(1'b1, 8'h10, 32'hFF, rd, er);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    check("unmapped_rd", rd, 32'h0);
    check("unmapped_err", er, 1'b1);
    apb(1'b1, `ASB_STATUS_BYTE_ADDR, 32'h27, rd, er);
    apb(1'b0, `ASB_STATUS_BYTE_ADDR, 32'h0, rd, er);
    check("apb_wr_rd", rd, m_st);
    check("mapped_err", er, 1'b0);
    op(1, 3, 1, 0);
    // Flag-neutral move into the status register, as software is advised
    op(0, 3, 1, 8'h03);
    // Event order covers each reset-cause source
    ev(2);
    ev(0);
    ev(1);
    ev(2);
    // Random mix of bus writes and all five operation kinds, moves included, both banks
    repeat (80)
    begin
      if ($urandom % 4 == 0)
        apb(1'b1, `ASB_STATUS_BYTE_ADDR, $urandom & 32'h0000003F, rd, er);
      else
        op($urandom % 5, ($urandom % 2) ? 3 : $urandom % 128, $urandom % 2, $urandom % 256);
    end
    rst_seq();
    close_out();
  end
endmodule
